// >>> core/sari_defines.vh
// sari_defines.vh: constants for the serial converter readout block
// assumes inclusion by bare name from core files only
`ifndef SARI_DEFINES_VH
`define SARI_DEFINES_VH
`define SARI_RES_BITS 12
`define SARI_CNT_W 4
`define SARI_CLK_NS 10
// conversion time of the fastest grade, in ns
`define SARI_CONVERT_START_NS 1500
`define SARI_CONVERT_START_CYC ((`SARI_CONVERT_START_NS + `SARI_CLK_NS - 1) / `SARI_CLK_NS)
`define SARI_CONVERT_START_W 8
// last count of a conversion, one less than the cycle count
`define SARI_CONVERT_START_LAST 8'h95
// synchroniser reset value for the sampled input word
`define SARI_SYNC_RST 12'h000
// result model reset value
`define SARI_SAMPLE_RST 12'hA5C
`endif

// >>> core/sari_readout.v
// sari_readout.v: digital control and serial readout of a 12-bit converter
// assumes convert and shift clock come from an outside host, asynchronous to clk
`timescale 1ns/1ps
`include "sari_defines.vh"

// Overview of operation
// - a rising edge of convert input starts a conversion
// - after conversion the block falls asleep by itself
// - while convert is low the serial output is driven
// - the serial output changes only after shift clock or convert falling edges
// - twelve result bits MSB first, then zeros forever
// - convert rising releases the serial output to high impedance
// - convert falling enables the serial output after a short delay
// - next bit appears soon after shift clock falls, prior bit held meanwhile
// - convert falling puts the result MSB out; host samples on shift rising
module sari_readout (
  input wire clk, // 100 MHz system clock
  input wire rst, // asynchronous reset, active high
  input wire convertStart, // host convert input, asynchronous
  input wire shiftClock, // host shift clock, asynchronous
  input wire [11:0] analogSample, // digitised input value sampled at conversion end
  output reg serialDataOut, // serial data output value
  output reg serialDataOutEn_n, // low while the block drives serial data
  output reg sleeping, // high while powered down
  output reg converting // high during a conversion
);

  localparam ST_ACQ = 2'h0;
  localparam ST_CONVERT_START = 2'h1;
  localparam ST_SLEEP = 2'h2;
  localparam NUM_SYNC = 2;

  // pin index 0 is convert, index 1 is the shift clock
  wire [NUM_SYNC-1:0] pinRaw;
  wire [NUM_SYNC-1:0] pinLevel;
  wire [NUM_SYNC-1:0] pinRise;
  wire [NUM_SYNC-1:0] pinFall;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`SARI_CONVERT_START_W-1:0] convCnt_q;
  reg [`SARI_CONVERT_START_W-1:0] convCnt_d;
  reg [`SARI_RES_BITS-1:0] sampleMeta_q;
  reg [`SARI_RES_BITS-1:0] sampleSync_q;
  reg [`SARI_RES_BITS-1:0] result_q;
  reg [`SARI_RES_BITS-1:0] result_d;
  reg [`SARI_RES_BITS-1:0] shift_q;
  reg [`SARI_RES_BITS-1:0] shift_d;
  reg serialDataOut_d;
  reg serialDataOutEn_n_d;
  reg sleeping_d;
  reg converting_d;

  wire convLevel;
  wire convRise;
  wire convFall;
  wire sckFall;
  wire convDone;

  assign pinRaw = {shiftClock, convertStart};

  // two flip-flops per pin, a third one only for edge detection
  genvar g;
  generate
    for (g = 0; g < NUM_SYNC; g = g + 1) begin : gSync
      reg meta_q;
      reg level_q;
      reg last_q;

      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q <= 1'h0;
          level_q <= 1'h0;
          last_q <= 1'h0;
        end else begin
          meta_q <= pinRaw[g];
          level_q <= meta_q;
          last_q <= level_q;
        end
      end

      assign pinLevel[g] = level_q;
      assign pinRise[g] = level_q & ~last_q;
      assign pinFall[g] = ~level_q & last_q;
    end
  endgenerate

  // input word passes two flip-flops before the result latch reads it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleMeta_q <= `SARI_SYNC_RST;
      sampleSync_q <= `SARI_SYNC_RST;
    end else begin
      sampleMeta_q <= analogSample;
      sampleSync_q <= sampleMeta_q;
    end
  end

  assign convLevel = pinLevel[0];
  assign convRise = pinRise[0];
  assign convFall = pinFall[0];
  assign sckFall = pinFall[1];
  assign convDone = (state_q == ST_CONVERT_START) && (convCnt_q == `SARI_CONVERT_START_LAST);

  // only a rising convert edge leaves acquisition; sleep is left on either convert edge
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_ACQ: begin
        if (convRise) state_d = ST_CONVERT_START;
      end
      ST_CONVERT_START: begin
        if (convDone) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (convFall) state_d = ST_ACQ;
        else if (convRise) state_d = ST_CONVERT_START;
      end
      default: begin
        state_d = ST_ACQ;
      end
    endcase
  end

  always @* begin
    convCnt_d = {`SARI_CONVERT_START_W{1'h0}};
    if (state_q == ST_CONVERT_START) convCnt_d = convCnt_q + 1'h1;
  end

  always @* begin
    result_d = result_q;
    if (convDone) result_d = sampleSync_q;
  end

  // convert fall loads the word; shift clock falls move it on, zeros fill in
  always @* begin
    shift_d = shift_q;
    serialDataOut_d = serialDataOut;
    if (convFall) begin
      serialDataOut_d = result_q[`SARI_RES_BITS-1];
      shift_d = {result_q[`SARI_RES_BITS-2:0], 1'h0};
    end else if (sckFall && !convLevel) begin
      serialDataOut_d = shift_q[`SARI_RES_BITS-1];
      shift_d = {shift_q[`SARI_RES_BITS-2:0], 1'h0};
    end
  end

  // the driver follows the synchronised convert level
  always @* begin
    serialDataOutEn_n_d = convLevel;
  end

  always @* begin
    sleeping_d = (state_d == ST_SLEEP);
    converting_d = (state_d == ST_CONVERT_START);
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_ACQ;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      convCnt_q <= {`SARI_CONVERT_START_W{1'h0}};
    end else begin
      convCnt_q <= convCnt_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_q <= `SARI_SAMPLE_RST;
    end else begin
      result_q <= result_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= {`SARI_RES_BITS{1'h0}};
    end else begin
      shift_q <= shift_d;
    end
  end

  // previous bit stays in place until the next load or shift
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serialDataOut <= 1'h0;
    end else begin
      serialDataOut <= serialDataOut_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serialDataOutEn_n <= 1'h1;
    end else begin
      serialDataOutEn_n <= serialDataOutEn_n_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sleeping <= 1'h0;
    end else begin
      sleeping <= sleeping_d;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      converting <= 1'h0;
    end else begin
      converting <= converting_d;
    end
  end

endmodule // sari_readout

// >>> tb/sari_host_model.sv
// sari_host_model.sv: host side of the serial readout link
// assumes it is called at falling clk edges; shift clock period 160 ns, idle low
`timescale 1ns/1ps
module sari_host_model (
  input wire clk, // bench clock
  input wire dataLine, // resolved serial data line
  output logic convertStart = 1'h0, // convert pin
  output logic shiftClock = 1'h0 // shift clock pin
);
  task automatic raiseConvert(input int holdCycles);
    convertStart = 1'h1;
    repeat (holdCycles) @(negedge clk);
  endtask
  task automatic dropConvert(input int waitCycles);
    convertStart = 1'h0;
    repeat (waitCycles) @(negedge clk);
  endtask
  task automatic pulseShift(input int pulses);
    for (int i = 0; i < pulses; i++) begin
      shiftClock = 1'h1;
      repeat (8) @(negedge clk);
      shiftClock = 1'h0;
      repeat (8) @(negedge clk);
    end
  endtask
  task automatic readOut(output logic [15:0] word);
    convertStart = 1'h0;
    repeat (8) @(negedge clk);
    for (int i = 15; i >= 0; i--) begin
      shiftClock = 1'h1;
      word[i] = dataLine;
      repeat (8) @(negedge clk);
      shiftClock = 1'h0;
      repeat (8) @(negedge clk);
    end
    repeat (60) @(negedge clk);
  endtask
endmodule // sari_host_model

// >>> tb/sari_readout_checker.sv
// sari_readout_checker.sv: concurrent checks on the readout block's ports
// assumes binding into sari_readout, one clk domain, active-high rst
`timescale 1ns/1ps
module sari_readout_checker (
  input wire clk, // system clock
  input wire rst, // asynchronous reset, active high
  input wire convertStart, // host convert pin
  input wire shiftClock, // host shift clock pin
  input wire serialDataOut, // serial data value
  input wire serialDataOutEn_n, // low while driving
  input wire sleeping, // sleep flag
  input wire converting // conversion flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rel; $rose(convertStart) |-> ##4 serialDataOutEn_n; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_ena; $fell(convertStart) |-> ##4 !serialDataOutEn_n; endproperty
  a_ena: assert property (p_ena) else $error("no enable");
  property p_data;
    $changed(serialDataOut) |-> ($past(shiftClock, 4) && !$past(shiftClock, 3)) ||
      ($past(convertStart, 4) && !$past(convertStart, 3));
  endproperty
  a_data: assert property (p_data) else $error("data moved off a falling edge");
  property p_start; $rose(convertStart) |-> ##3 converting; endproperty
  a_start: assert property (p_start) else $error("conversion not started");
  property p_cause;
    $rose(converting) |-> $past(convertStart, 3) && !$past(convertStart, 4);
  endproperty
  a_cause: assert property (p_cause) else $error("conversion without rising edge");
  property p_sleep; $fell(converting) |-> sleeping; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after conversion");
  property p_drive;
    (!convertStart && !$past(convertStart, 1) && !$past(convertStart, 2) &&
      !$past(convertStart, 3) && !$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3))
      |-> !serialDataOutEn_n;
  endproperty
  a_drive: assert property (p_drive) else $error("output not driven while low");
  c_convert_start: cover property ($rose(converting));
  c_sleep: cover property ($rose(sleeping));
  c_shift: cover property ($fell(shiftClock) && !serialDataOutEn_n);
  c_refused: cover property ($fell(shiftClock) && convertStart);
endmodule // sari_readout_checker
bind sari_readout sari_readout_checker i_sari_readout_checker (.*);

// >>> tb/test_serial_adc_readout_interface.sv
// test_serial_adc_readout_interface.sv: scenarios for the converter readout block
// assumes the host model drives the link and the checker is bound into the design
`timescale 1ns/1ps
module test_serial_adc_readout_interface;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] analogSample = 12'hA53;
  logic [15:0] word;
  wire convertStart;
  wire shiftClock;
  wire serialDataOut;
  wire serialDataOutEn_n;
  wire sleeping;
  wire converting;
  wire dataLine;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  // a released line reads as the inverse of the last driven value
  assign dataLine = serialDataOutEn_n ? ~serialDataOut : serialDataOut;
  always #5 clk = ~clk;

  sari_readout i_sari_readout (
    .clk(clk),
    .rst(rst),
    .convertStart(convertStart),
    .shiftClock(shiftClock),
    .analogSample(analogSample),
    .serialDataOut(serialDataOut),
    .serialDataOutEn_n(serialDataOutEn_n),
    .sleeping(sleeping),
    .converting(converting)
  );
  sari_host_model i_sari_host_model (
    .clk(clk),
    .dataLine(dataLine),
    .convertStart(convertStart),
    .shiftClock(shiftClock)
  );

  task automatic checkWord(input string name, input logic [15:0] want);
    total_checks++;
    if (word !== want) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, want, word);
    end
  endtask
  task automatic checkFlag(input string name, input logic want, input logic seen);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", name, want, seen);
    end
  endtask

  // one conversion and a 16-clock readout; shift pulses while high must be ignored
  task automatic readOneWord(input logic [11:0] sample, input int ignoredPulses);
    analogSample = sample;
    i_sari_host_model.raiseConvert(10);
    checkFlag("converting", 1'h1, converting);
    checkFlag("outputEnableN", 1'h1, serialDataOutEn_n);
    i_sari_host_model.raiseConvert(150);
    i_sari_host_model.pulseShift(ignoredPulses);
    checkFlag("sleeping", 1'h1, sleeping);
    checkFlag("convertingDone", 1'h0, converting);
    i_sari_host_model.readOut(word);
    checkWord("word", {sample, 4'h0});
  endtask

  task automatic midRunReset;
    i_sari_host_model.raiseConvert(160);
    i_sari_host_model.dropConvert(20);
    rst = 1'h1;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    checkFlag("convertingAfterReset", 1'h0, converting);
    @(negedge clk);
    checkFlag("sleepingAfterReset", 1'h0, sleeping);
    repeat (4) @(negedge clk);
    checkFlag("drivenAfterReset", 1'h0, serialDataOutEn_n);
  endtask

  task automatic complete_run;
    if (cycles >= 4000) begin
      num_errors++;
      $display("[FAIL] timeout expected below 4000 seen %0d", cycles);
    end
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) complete_run();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    readOneWord(12'hA53, 0);
    readOneWord(12'h3C6, 3);
    midRunReset();
    readOneWord(12'h5A6, 0);
    complete_run();
  end
endmodule // test_serial_adc_readout_interface
